/* File: src/sysref_ctl_pkg.sv */
// package for the sync reference pattern generator control block
// assumes one 250 mhz system clock and the register port of the serial control logic
package sysref_ctl_pkg;

	// --------------------------------------------------------------
	// register offsets
	// --------------------------------------------------------------
	localparam logic [15:0] OFS_KDIV_LO         = 16'h0400;
	localparam logic [15:0] OFS_KDIV_HI         = 16'h0401;
	localparam logic [15:0] OFS_SYNC_REF_CTRL   = 16'h0402;
	localparam logic [15:0] OFS_SYNC_REF_SRCPAT = 16'h0403;
	localparam logic [15:0] OFS_SYNC_REF_RX     = 16'h0404;

	// --------------------------------------------------------------
	// reset values
	// --------------------------------------------------------------
	localparam logic [7:0]  RST_CTRL   = 8'h04;
	localparam logic [7:0]  RST_SRCPAT = 8'h00;
	localparam logic [2:0]  RST_RX     = 3'h4;
	localparam logic [15:0] RST_KDIV   = 16'h0001;

	// --------------------------------------------------------------
	// field encodings
	// --------------------------------------------------------------
	localparam logic [1:0] TEST_LOW   = 2'h0;
	localparam logic [1:0] TEST_HIGH  = 2'h1;
	localparam logic [1:0] SRC_EXT    = 2'h0;
	localparam logic [1:0] SRC_EXT_RS = 2'h1;
	localparam logic [1:0] SRC_INT    = 2'h2;
	localparam logic [1:0] MODE_NSHOT = 2'h0;
	localparam logic [1:0] MODE_CONT  = 2'h1;
	localparam logic [1:0] MODE_STOP  = 2'h3;
	localparam logic [1:0] TRIG_RISE  = 2'h2;
	localparam logic [1:0] TRIG_FALL  = 2'h3;
	localparam int         RX_PD_BIT  = 2;
	localparam int         RX_NEG_BIT = 1;
	localparam int         RX_DIFF_BIT = 0;

	// synchroniser lanes
	localparam int SY_REQ  = 0;
	localparam int SY_EXT  = 1;
	localparam int SY_P2FB = 2;
	localparam int SY_P1   = 3;
	localparam int SY_DEV  = 4;
	localparam int SY_W    = 5;

	// control register, bit 7 down to bit 0
	typedef struct packed {
		logic       pin_method;
		logic [1:0] trig;
		logic       gen_clk_p1;
		logic       rs_clk_p1;
		logic [1:0] test;
		logic       reset;
	} ctrl_t;

	// source and pattern register, bit 7 down to bit 0
	typedef struct packed {
		logic [1:0] source;
		logic [1:0] mode;
		logic [2:0] nshot;
		logic       req;
	} srcpat_t;

endpackage

/* File: src/sync3.sv */
// three stage input synchroniser with agreement filter, one lane per bit
// assumes inputs are asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module sync3 #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] out_ff;
	logic [W-1:0] nxt_out;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_lane
			// a change is taken only once stages two and three agree
			always_comb begin
				nxt_out[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : out_ff[i];
			end
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s1_ff  <= '0;
			s2_ff  <= '0;
			s3_ff  <= '0;
			out_ff <= '0;
		end else begin
			s1_ff  <= async_in;
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			out_ff <= nxt_out;
		end
	end

	assign sync_out = out_ff;
endmodule
`default_nettype wire

/* File: src/sysref_pattern_ctl.sv */
// sync reference source select, pattern generator and receiver control
// assumes generator and resample clocks are far slower than clk_sys; they are sampled
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - register bit or pin request, pin sensitivity select
// - generator clock: pll2 feedback or pll1
// - resample clock: device clock or pll1
// - test mode forces low, high, or passes the selected source
// - source: external, external resampled, internal generator
// - pattern mode: n-shot, continuous, stop
// - n-shot burst count, request bit self-clears
// - continuous runs until request bit cleared
// - receiver power-down control, zero enables both
// - single-ended polarity picks negative or positive
// - differential enable disables single-ended receivers
// - sixteen bit divider sets pulse width
module sysref_pattern_ctl (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [15:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        sync_ref_receiver_pin,
	input  wire logic        req_pin,
	input  wire logic        pll2_fb_clk,
	input  wire logic        pll1_clk,
	input  wire logic        dev_clk,
	output logic             sysref_out,
	output logic             gen_busy,
	output logic             rx_pos_en,
	output logic             rx_neg_en,
	output logic             rx_diff_en
);
	typedef enum logic [1:0] {ST_IDLE, ST_HIGH, ST_LOW} gen_state_t;

	// --------------------------------------------------------------
	// input sampling
	// --------------------------------------------------------------
	logic [sysref_ctl_pkg::SY_W-1:0] sy;
	logic [sysref_ctl_pkg::SY_W-1:0] sy_prev_ff;

	sync3 #(.W(sysref_ctl_pkg::SY_W)) u_sync (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.async_in ({dev_clk, pll1_clk, pll2_fb_clk, sync_ref_receiver_pin, req_pin}),
		.sync_out (sy)
	);

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	sysref_ctl_pkg::ctrl_t   ctrl_ff,   nxt_ctrl;
	sysref_ctl_pkg::srcpat_t srcpat_ff, nxt_srcpat;
	logic [2:0]              rx_ff,     nxt_rx;
	logic [15:0]             kdiv_ff,   nxt_kdiv;
	logic [7:0]              rdata_ff,  nxt_rdata;
	logic                    req_prev_ff;

	// --------------------------------------------------------------
	// generator state
	// --------------------------------------------------------------
	gen_state_t  state_ff,   nxt_state;
	logic [15:0] div_ff,     nxt_div;
	logic [3:0]  pulses_ff,  nxt_pulses;
	logic        rs_ff,      nxt_rs;
	logic        out_ff,     nxt_out;
	logic        pos_ff,     neg_ff, diff_ff;
	logic        nxt_pos,    nxt_neg, nxt_diff;
	logic        busy_ff;

	logic        gen_tick, rs_tick, pin_now, pin_was;
	logic        start, keep, boundary, last_pulse, nshot_done, mode_ok;
	logic [15:0] k_last;
	logic [3:0]  target;

	always_comb begin
		// selected clocks seen as rising edges of their sampled copies
		gen_tick = ctrl_ff.gen_clk_p1
			? (sy[sysref_ctl_pkg::SY_P1] & ~sy_prev_ff[sysref_ctl_pkg::SY_P1])
			: (sy[sysref_ctl_pkg::SY_P2FB] & ~sy_prev_ff[sysref_ctl_pkg::SY_P2FB]);
		rs_tick = ctrl_ff.rs_clk_p1
			? (sy[sysref_ctl_pkg::SY_P1] & ~sy_prev_ff[sysref_ctl_pkg::SY_P1])
			: (sy[sysref_ctl_pkg::SY_DEV] & ~sy_prev_ff[sysref_ctl_pkg::SY_DEV]);
		pin_now = sy[sysref_ctl_pkg::SY_REQ];
		pin_was = sy_prev_ff[sysref_ctl_pkg::SY_REQ];
		// a zero divider is treated as one so the pattern still toggles
		k_last = (kdiv_ff == 16'h0000) ? 16'h0000 : kdiv_ff - 16'h0001;
		unique case (srcpat_ff.nshot)
			3'h1:    target = 4'h1;
			3'h2:    target = 4'h2;
			3'h3:    target = 4'h4;
			3'h4:    target = 4'h6;
			3'h5:    target = 4'h8;
			default: target = 4'h1;
		endcase
		mode_ok = (srcpat_ff.mode == sysref_ctl_pkg::MODE_NSHOT)
			| (srcpat_ff.mode == sysref_ctl_pkg::MODE_CONT);
		if (!ctrl_ff.pin_method) begin
			start = srcpat_ff.req & ~req_prev_ff;
			keep  = srcpat_ff.req;
		end else if (ctrl_ff.trig == sysref_ctl_pkg::TRIG_RISE) begin
			start = pin_now & ~pin_was;
			keep  = 1'b1;
		end else if (ctrl_ff.trig == sysref_ctl_pkg::TRIG_FALL) begin
			start = ~pin_now & pin_was;
			keep  = 1'b1;
		end else begin
			start = pin_now;
			keep  = pin_now;
		end
		boundary   = (state_ff == ST_LOW) & gen_tick & (div_ff == k_last);
		last_pulse = (pulses_ff + 4'h1) == target;
		nshot_done = boundary & (srcpat_ff.mode == sysref_ctl_pkg::MODE_NSHOT) & last_pulse;
	end

	// --------------------------------------------------------------
	// register file
	// --------------------------------------------------------------
	always_comb begin
		nxt_ctrl   = ctrl_ff;
		nxt_srcpat = srcpat_ff;
		nxt_rx     = rx_ff;
		nxt_kdiv   = kdiv_ff;
		nxt_rdata  = 8'h00;
		// hardware clear first so a same-cycle write setting the bit wins
		if (nshot_done & ~ctrl_ff.pin_method)
			nxt_srcpat.req = 1'b0;
		if (reg_wr) begin
			unique case (reg_addr)
				sysref_ctl_pkg::OFS_KDIV_LO:         nxt_kdiv[7:0]  = reg_wdata;
				sysref_ctl_pkg::OFS_KDIV_HI:         nxt_kdiv[15:8] = reg_wdata;
				sysref_ctl_pkg::OFS_SYNC_REF_CTRL:   nxt_ctrl       = reg_wdata;
				sysref_ctl_pkg::OFS_SYNC_REF_SRCPAT: nxt_srcpat     = reg_wdata;
				sysref_ctl_pkg::OFS_SYNC_REF_RX:     nxt_rx         = reg_wdata[2:0];
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				sysref_ctl_pkg::OFS_KDIV_LO:         nxt_rdata = kdiv_ff[7:0];
				sysref_ctl_pkg::OFS_KDIV_HI:         nxt_rdata = kdiv_ff[15:8];
				sysref_ctl_pkg::OFS_SYNC_REF_CTRL:   nxt_rdata = ctrl_ff;
				sysref_ctl_pkg::OFS_SYNC_REF_SRCPAT: nxt_rdata = srcpat_ff;
				sysref_ctl_pkg::OFS_SYNC_REF_RX:     nxt_rdata = {5'h00, rx_ff};
				default:                             nxt_rdata = 8'h00;
			endcase
		end
	end

	// --------------------------------------------------------------
	// pattern generator
	// --------------------------------------------------------------
	always_comb begin
		nxt_state  = state_ff;
		nxt_div    = div_ff;
		nxt_pulses = pulses_ff;
		if (ctrl_ff.reset) begin
			nxt_state  = ST_IDLE;
			nxt_div    = 16'h0000;
			nxt_pulses = 4'h0;
		end else begin
			unique case (state_ff)
				ST_IDLE: begin
					if (start & mode_ok) begin
						nxt_state  = ST_HIGH;
						nxt_div    = 16'h0000;
						nxt_pulses = 4'h0;
					end
				end
				ST_HIGH: begin
					if (gen_tick) begin
						nxt_div = div_ff + 16'h0001;
						if (div_ff == k_last) begin
							nxt_state = ST_LOW;
							nxt_div   = 16'h0000;
						end
					end
				end
				ST_LOW: begin
					if (gen_tick)
						nxt_div = div_ff + 16'h0001;
					if (boundary) begin
						nxt_div    = 16'h0000;
						nxt_pulses = pulses_ff + 4'h1;
						nxt_state  = ST_HIGH;
						// stop or invalid mode ends the burst here
						if (!mode_ok)
							nxt_state = ST_IDLE;
						else if (nshot_done)
							nxt_state = ST_IDLE;
						else if (srcpat_ff.mode == sysref_ctl_pkg::MODE_CONT && !keep)
							nxt_state = ST_IDLE;
					end
				end
				default: nxt_state = ST_IDLE;
			endcase
		end
	end

	// --------------------------------------------------------------
	// output path and receivers
	// --------------------------------------------------------------
	always_comb begin
		logic path;
		path   = 1'b0;
		nxt_rs = rs_tick ? sy[sysref_ctl_pkg::SY_EXT] : rs_ff;
		unique case (srcpat_ff.source)
			sysref_ctl_pkg::SRC_EXT:    path = sy[sysref_ctl_pkg::SY_EXT];
			sysref_ctl_pkg::SRC_EXT_RS: path = rs_ff;
			sysref_ctl_pkg::SRC_INT:    path = (state_ff == ST_HIGH);
			default:                    path = 1'b0;
		endcase
		if (ctrl_ff.test == sysref_ctl_pkg::TEST_LOW)
			nxt_out = 1'b0;
		else if (ctrl_ff.test == sysref_ctl_pkg::TEST_HIGH)
			nxt_out = 1'b1;
		else
			nxt_out = path;
		nxt_diff = rx_ff[sysref_ctl_pkg::RX_DIFF_BIT];
		nxt_pos  = ~nxt_diff & (~rx_ff[sysref_ctl_pkg::RX_PD_BIT]
			| ~rx_ff[sysref_ctl_pkg::RX_NEG_BIT]);
		nxt_neg  = ~nxt_diff & (~rx_ff[sysref_ctl_pkg::RX_PD_BIT]
			| rx_ff[sysref_ctl_pkg::RX_NEG_BIT]);
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_ff     <= sysref_ctl_pkg::RST_CTRL;
			srcpat_ff   <= sysref_ctl_pkg::RST_SRCPAT;
			rx_ff       <= sysref_ctl_pkg::RST_RX;
			kdiv_ff     <= sysref_ctl_pkg::RST_KDIV;
			rdata_ff    <= 8'h00;
			req_prev_ff <= 1'b0;
			sy_prev_ff  <= '0;
			state_ff    <= ST_IDLE;
			div_ff      <= 16'h0000;
			pulses_ff   <= 4'h0;
			rs_ff       <= 1'b0;
			out_ff      <= 1'b0;
			pos_ff      <= 1'b0;
			neg_ff      <= 1'b0;
			diff_ff     <= 1'b0;
			busy_ff     <= 1'b0;
		end else begin
			ctrl_ff     <= nxt_ctrl;
			srcpat_ff   <= nxt_srcpat;
			rx_ff       <= nxt_rx;
			kdiv_ff     <= nxt_kdiv;
			rdata_ff    <= nxt_rdata;
			req_prev_ff <= srcpat_ff.req;
			sy_prev_ff  <= sy;
			state_ff    <= nxt_state;
			div_ff      <= nxt_div;
			pulses_ff   <= nxt_pulses;
			rs_ff       <= nxt_rs;
			out_ff      <= nxt_out;
			pos_ff      <= nxt_pos;
			neg_ff      <= nxt_neg;
			diff_ff     <= nxt_diff;
			busy_ff     <= (nxt_state != ST_IDLE);
		end
	end

	assign reg_rdata  = rdata_ff;
	assign sysref_out = out_ff;
	assign rx_pos_en  = pos_ff;
	assign rx_neg_en  = neg_ff;
	assign rx_diff_en = diff_ff;
	assign gen_busy   = busy_ff;

	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	reset_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
		ctrl_ff.reset |=> (state_ff == ST_IDLE) && (pulses_ff == 4'h0))
		else $error("generator not idle under reset bit");
	test_low_a: assert property (@(posedge clk_sys) disable iff (rst)
		(ctrl_ff.test == sysref_ctl_pkg::TEST_LOW) |=> !sysref_out)
		else $error("test low mode drove output high");
	test_high_a: assert property (@(posedge clk_sys) disable iff (rst)
		(ctrl_ff.test == sysref_ctl_pkg::TEST_HIGH) |=> sysref_out)
		else $error("test high mode drove output low");
	spi_start_a: assert property (@(posedge clk_sys) disable iff (rst)
		(state_ff == ST_IDLE) && !ctrl_ff.reset && !ctrl_ff.pin_method && mode_ok
		&& srcpat_ff.req && !req_prev_ff |=> (state_ff == ST_HIGH))
		else $error("register request did not start the pattern");
	pin_fall_a: assert property (@(posedge clk_sys) disable iff (rst)
		(state_ff == ST_IDLE) && !ctrl_ff.reset && ctrl_ff.pin_method && mode_ok
		&& (ctrl_ff.trig == sysref_ctl_pkg::TRIG_FALL) && !pin_now && pin_was
		|=> (state_ff == ST_HIGH))
		else $error("falling pin edge did not start the pattern");
	nshot_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
		nshot_done && !ctrl_ff.reset && !ctrl_ff.pin_method && !reg_wr
		|=> !srcpat_ff.req && (state_ff == ST_IDLE))
		else $error("n-shot burst end did not clear request");
	cont_stop_a: assert property (@(posedge clk_sys) disable iff (rst)
		boundary && !ctrl_ff.reset && !ctrl_ff.pin_method && !srcpat_ff.req
		&& (srcpat_ff.mode == sysref_ctl_pkg::MODE_CONT) |=> (state_ff == ST_IDLE))
		else $error("continuous pattern ran on after request cleared");
	stop_mode_a: assert property (@(posedge clk_sys) disable iff (rst)
		boundary && !ctrl_ff.reset && (srcpat_ff.mode == sysref_ctl_pkg::MODE_STOP)
		|=> (state_ff == ST_IDLE) ##1 (state_ff == ST_IDLE))
		else $error("stop mode did not end the burst");
	high_width_a: assert property (@(posedge clk_sys) disable iff (rst)
		(state_ff == ST_HIGH) && gen_tick && (div_ff == k_last) && !ctrl_ff.reset
		|=> (state_ff == ST_LOW) && (div_ff == 16'h0000))
		else $error("high phase length differs from divider");
	diff_rx_a: assert property (@(posedge clk_sys) disable iff (rst)
		rx_ff[sysref_ctl_pkg::RX_DIFF_BIT] |=> rx_diff_en && !rx_pos_en && !rx_neg_en)
		else $error("differential mode left a single-ended receiver on");
	pol_sel_a: assert property (@(posedge clk_sys) disable iff (rst)
		(rx_ff == 3'h6) |=> rx_neg_en && !rx_pos_en)
		else $error("negative receiver not selected");
	pd_off_a: assert property (@(posedge clk_sys) disable iff (rst)
		(rx_ff == 3'h0) |=> rx_neg_en && rx_pos_en)
		else $error("power-down control off did not enable both receivers");
endmodule
`default_nettype wire

/* File: verification/sysref_far_side.sv */
// far side model: slow reference clocks, the request pin and the sync reference pin
// assumes the bench sets pin levels through the two tasks, off the clk_sys sampling edge
`timescale 1ns/1ps
`default_nettype none
module sysref_far_side (
	output logic pll2_fb_clk,
	output logic pll1_clk,
	output logic dev_clk,
	output logic req_pin,
	output logic sync_ref_receiver_pin
);
	// ----------------------------------------------------------
	// free clocks, phase unrelated to clk_sys
	// ----------------------------------------------------------
	// each level holds at least three clk_sys cycles so every tick is seen
	initial begin
		pll2_fb_clk = 1'b0;
		#1.3;
		forever #16 pll2_fb_clk = ~pll2_fb_clk;
	end
	initial begin
		pll1_clk = 1'b0;
		#2.7;
		forever #32 pll1_clk = ~pll1_clk;
	end
	initial begin
		dev_clk = 1'b0;
		#0.9;
		forever #20 dev_clk = ~dev_clk;
	end
	initial begin
		req_pin = 1'b0;
		sync_ref_receiver_pin = 1'b0;
	end
	task automatic set_req(input logic v);
		req_pin = v;
	endtask
	task automatic set_ext(input logic v);
		sync_ref_receiver_pin = v;
	endtask
endmodule
`default_nettype wire

/* File: verification/sysref_pattern_generator_control_tb.sv */
// self-checking bench for the sync reference pattern generator control block
// assumes the far side model makes the slow clocks and pin levels
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
	$display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module sysref_pattern_generator_control_tb;
	logic        clk_sys;
	logic        rst;
	logic [15:0] reg_addr;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic [7:0]  rdat;
	logic [15:0] kv;
	logic        reg_wr;
	logic        reg_rd;
	logic        v;
	wire         ext_pin, rq_pin, p2_clk, p1_clk, d_clk;
	wire         sysref_out, gen_busy, rx_pos_en, rx_neg_en, rx_diff_en;
	int          error_cnt, n_compared, cyc, seed, n, i, w;
	logic [15:0] ra [6] = '{16'h0400, 16'h0401, 16'h0402, 16'h0403, 16'h0404, 16'h0405};
	logic [7:0]  rv [6] = '{8'h01, 8'h00, 8'h04, 8'h00, 8'h04, 8'h00};

	sysref_pattern_ctl u_sysref_pattern_ctl (.clk_sys(clk_sys), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sync_ref_receiver_pin(ext_pin), .req_pin(rq_pin),
		.pll2_fb_clk(p2_clk), .pll1_clk(p1_clk), .dev_clk(d_clk),
		.sysref_out(sysref_out), .gen_busy(gen_busy), .rx_pos_en(rx_pos_en),
		.rx_neg_en(rx_neg_en), .rx_diff_en(rx_diff_en));
	sysref_far_side u_sysref_far_side (.pll2_fb_clk(p2_clk), .pll1_clk(p1_clk),
		.dev_clk(d_clk), .req_pin(rq_pin), .sync_ref_receiver_pin(ext_pin));

	// ----------------------------------------------------------
	// reference model
	// ----------------------------------------------------------
	function automatic int nshot(input int c);
		case (c)
			1: return 1;
			2: return 2;
			3: return 4;
			4: return 6;
			5: return 8;
			default: return 1;
		endcase
	endfunction
	// differential wins over the power-down control
	function automatic logic [2:0] rx_exp(input logic [2:0] r);
		if (r[0])
			return 3'h1;
		return {~r[2] | ~r[1], ~r[2] | r[1], 1'b0};
	endfunction

	// ----------------------------------------------------------
	// register port and wait tasks
	// ----------------------------------------------------------
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a);
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		rdat = reg_rdata;
	endtask
	task automatic wt(input bit on_out, input logic lv, input int lim);
		int k;
		for (k = 0; k < lim; k++) begin
			if ((on_out ? sysref_out : gen_busy) === lv)
				break;
			@(negedge clk_sys);
		end
		`CHK(on_out ? sysref_out : gen_busy, lv)
	endtask
	task automatic count_burst(output int cnt);
		logic p;
		int k;
		cnt = 0;
		p = 1'b0;
		for (k = 0; k < 3000 && gen_busy !== 1'b0; k++) begin
			@(negedge clk_sys);
			if (sysref_out === 1'b1 && p !== 1'b1)
				cnt++;
			p = sysref_out;
		end
	endtask
	task automatic high_width(output int hw);
		int k;
		hw = 0;
		for (k = 0; k < 400 && sysref_out !== 1'b1; k++)
			@(negedge clk_sys);
		for (k = 0; k < 400 && sysref_out === 1'b1; k++) begin
			@(negedge clk_sys);
			hw++;
		end
	endtask
	task automatic test_done(input string s);
		$display("test %s done", s);
	endtask
	task automatic end_sim;
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ----------------------------------------------------------
	// clock and timeout
	// ----------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			end_sim();
		end
	end

	// ----------------------------------------------------------
	// tests
	// ----------------------------------------------------------
	initial begin
		rst = 1'b1;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		seed = 90522;
		repeat (12) @(negedge clk_sys);
		rst = 1'b0;
		for (i = 0; i < 6; i++) begin
			rd(ra[i]);
			`CHK(rdat, rv[i])
		end
		`CHK({rx_pos_en, rx_neg_en, rx_diff_en}, 3'h4)
		for (i = 0; i < 8; i++) begin
			wr(16'h0404, {5'h1F, i[2:0]});
			rd(16'h0404);
			`CHK(rdat, {5'h00, i[2:0]})
			`CHK({rx_pos_en, rx_neg_en, rx_diff_en}, rx_exp(i[2:0]))
		end
		// random divider values, both bytes independent
		for (i = 0; i < 4; i++) begin
			kv = 16'($random(seed));
			wr(16'h0400, kv[7:0]);
			wr(16'h0401, kv[15:8]);
			rd(16'h0400);
			`CHK(rdat, kv[7:0])
			rd(16'h0401);
			`CHK(rdat, kv[15:8])
		end
		wr(16'h0400, 8'h01);
		wr(16'h0401, 8'h00);
		test_done("registers");
		wr(16'h0402, 8'h00);
		wt(1, 1'b0, 4);
		wr(16'h0402, 8'h02);
		wt(1, 1'b1, 4);
		wr(16'h0402, 8'h04);
		for (i = 0; i < 8; i++) begin
			v = 1'($random(seed));
			u_sysref_far_side.set_ext(v);
			wt(1, v, 12);
		end
		for (i = 0; i < 2; i++) begin
			wr(16'h0402, i[0] ? 8'h0C : 8'h04);
			wr(16'h0403, 8'h40);
			u_sysref_far_side.set_ext(1'b1);
			wt(1, 1'b1, 60);
			u_sysref_far_side.set_ext(1'b0);
			wt(1, 1'b0, 60);
		end
		test_done("source and test level");
		wr(16'h0402, 8'h04);
		for (i = 0; i < 8; i++) begin
			wr(16'h0403, {4'h8, i[2:0], 1'b0});
			wr(16'h0403, {4'h8, i[2:0], 1'b1});
			wt(0, 1'b1, 20);
			count_burst(n);
			`CHK(n, nshot(i))
			rd(16'h0403);
			`CHK(rdat, {4'h8, i[2:0], 1'b0})
		end
		test_done("n-shot");
		wr(16'h0400, 8'h03);
		wr(16'h0403, 8'h91);
		wt(0, 1'b1, 20);
		// the first pulse starts off the tick grid, so measure the second
		high_width(w);
		high_width(w);
		`CHK(w, 24)
		wr(16'h0402, 8'h14);
		high_width(w);
		high_width(w);
		`CHK(w, 48)
		rd(16'h0403);
		`CHK(rdat, 8'h91)
		wr(16'h0403, 8'h90);
		wt(0, 1'b0, 400);
		wr(16'h0400, 8'h01);
		wr(16'h0402, 8'h04);
		test_done("continuous and width");
		wr(16'h0403, 8'h91);
		wt(0, 1'b1, 20);
		wr(16'h0403, 8'hB1);
		wt(0, 1'b0, 100);
		n = 0;
		// mode 11 stays quiet, then invalid mode 10 must not start either
		for (i = 0; i < 80; i++) begin
			if (i == 40)
				wr(16'h0403, 8'hA0);
			if (i == 41)
				wr(16'h0403, 8'hA1);
			@(negedge clk_sys);
			n += (sysref_out !== 1'b0 || gen_busy !== 1'b0);
		end
		`CHK(n, 0)
		wr(16'h0403, 8'h90);
		wr(16'h0403, 8'h91);
		wt(0, 1'b1, 20);
		wr(16'h0402, 8'h05);
		wt(0, 1'b0, 4);
		wt(1, 1'b0, 4);
		wr(16'h0402, 8'h04);
		wr(16'h0403, 8'h90);
		wr(16'h0403, 8'h91);
		wt(0, 1'b1, 20);
		wr(16'h0403, 8'h90);
		wt(0, 1'b0, 100);
		test_done("stop and reset bit");
		wr(16'h0403, 8'h84);
		for (i = 2; i < 4; i++) begin
			wr(16'h0402, {1'b1, i[1:0], 5'h04});
			u_sysref_far_side.set_req(1'b1);
			if (i == 3) begin
				repeat (10) @(negedge clk_sys);
				`CHK(gen_busy, 1'b0)
				u_sysref_far_side.set_req(1'b0);
			end
			wt(0, 1'b1, 20);
			count_burst(n);
			`CHK(n, 2)
			u_sysref_far_side.set_req(1'b0);
			// let the falling edge clear the synchroniser before the trigger changes
			repeat (8) @(negedge clk_sys);
		end
		wr(16'h0402, 8'h84);
		wr(16'h0403, 8'h90);
		u_sysref_far_side.set_req(1'b1);
		wt(0, 1'b1, 20);
		u_sysref_far_side.set_req(1'b0);
		wt(0, 1'b0, 200);
		test_done("pin request");
		end_sim();
	end
endmodule
`default_nettype wire
